// *** bench/lsc_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

module lsc_host_model (
    // Clock.
    input wire logic clock_i,
    // Byte register port toward the block.
    output logic [7:0] addr_o,
    output logic [7:0] wdata_o,
    output logic wr_o,
    output logic rd_o
);
    // Strobes idle low from time zero.
    initial begin
        addr_o = 8'h00;
        wdata_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
    end

    // One-cycle write strobe; released data flips so stale bytes never look valid.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clock_i);
        addr_o <= a;
        wdata_o <= d;
        wr_o <= 1'b1;
        @(posedge clock_i);
        wr_o <= 1'b0;
        wdata_o <= ~d;
    endtask : wr

    // One-cycle read strobe; the answer is collected by the bench watcher.
    task automatic rd(input logic [7:0] a);
        @(posedge clock_i);
        addr_o <= a;
        rd_o <= 1'b1;
        @(posedge clock_i);
        rd_o <= 1'b0;
        addr_o <= ~a;
    endtask : rd
endmodule : lsc_host_model
`default_nettype wire

// *** bench/tb_lsc_regs.sv ***
`timescale 1ns/1ps
`default_nettype none

module tb_lsc_regs;
    // Design pins and bench state.
    logic clock_i, arst_n_i, chip_en_i, mode_pin_i, fault_reset_i;
    logic vin_uv_i, vin_ov_i, reg_ocp_i, die_hot_i;
    logic [8:0] open_detect_i, ch_enable_o;
    logic [7:0] reg_addr_i, reg_wdata_i, reg_rdata_o;
    logic reg_wr_i, reg_rd_i, reg_rvalid_o, fault_o, fault_oe_o;
    logic regulator_run_o, light_load_skip_o;
    logic [53:0] ch_code_o;
    logic [7:0] exp_q[$];
    logic [7:0] cd[9];
    int fails = 0;
    int checks_done = 0;
    int cyc = 0;

    lsc_host_model host_u (.clock_i(clock_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i),
        .wr_o(reg_wr_i), .rd_o(reg_rd_i));

    lsc_regs dut_u (.clock_i(clock_i), .arst_n_i(arst_n_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .reg_rvalid_o(reg_rvalid_o),
        .open_detect_i(open_detect_i), .vin_uv_i(vin_uv_i), .vin_ov_i(vin_ov_i),
        .reg_ocp_i(reg_ocp_i), .die_hot_i(die_hot_i), .chip_en_i(chip_en_i),
        .mode_pin_i(mode_pin_i), .fault_reset_i(fault_reset_i), .fault_o(fault_o),
        .fault_oe_o(fault_oe_o), .ch_enable_o(ch_enable_o), .ch_code_o(ch_code_o),
        .regulator_run_o(regulator_run_o), .light_load_skip_o(light_load_skip_o));

    // Free-running 20 MHz clock.
    initial begin
        clock_i = 1'b0;
        forever #25 clock_i = ~clock_i;
    end

    task automatic chk(input string n, input logic [63:0] s, input logic [63:0] e);
        checks_done++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host_u.rd(a);
    endtask : rdx

    // Outputs lag a write by two edges; three leaves margin.
    task automatic settle;
        repeat (3) @(posedge clock_i);
        #1;
    endtask : settle

    task automatic conclude;
        if (fails == 0 && checks_done > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : conclude

    // Every read answer is matched against the oldest noted expectation.
    always @(posedge clock_i) begin
        if (reg_rvalid_o === 1'b1) begin
            if (exp_q.size() == 0) chk("spare_read", 1, 0);
            else chk("rdata", reg_rdata_o, exp_q.pop_front());
        end
    end

    // A hang is cut short well beyond the expected run length.
    always @(posedge clock_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            conclude();
        end
    end

    initial begin
        logic [7:0] e, g;
        logic [8:0] xe, m9;
        logic [53:0] xc, mc;
        logic [3:0] s;
        int u;
        arst_n_i = 1'b0;
        {chip_en_i, mode_pin_i, fault_reset_i} = 3'h0;
        {vin_uv_i, vin_ov_i, reg_ocp_i, die_hot_i} = 4'h0;
        open_detect_i = 9'h000;
        void'($urandom(87));
        repeat (3) @(posedge clock_i);
        arst_n_i <= 1'b1;
        // Every offset from 0x00 to 0x13, mapped or not, reads zero after power-on.
        for (int a = 0; a < 20; a++) rdx(8'(a), 8'h00);
        // Individual mode with junk in the shared fields and reserved bits.
        for (int i = 0; i < 9; i++) begin
            cd[i] = 8'($urandom);
            host_u.wr(8'(5 + i), cd[i]);
        end
        g = 8'($urandom);
        e = 8'($urandom);
        host_u.wr(8'h04, g);
        host_u.wr(8'h03, e);
        host_u.wr(8'h02, 8'h7F);
        host_u.wr(8'h0E, 8'hFF);
        host_u.wr(8'h12, 8'hFF);
        rdx(8'h02, 8'h3F);
        rdx(8'h03, e);
        rdx(8'h04, g & 8'h3F);
        for (int i = 0; i < 9; i++) rdx(8'(5 + i), cd[i] & 8'h3F);
        rdx(8'h0E, 8'h00);
        rdx(8'h12, 8'h00);
        settle();
        xe[0] = 1'b1;
        for (int n = 2; n < 10; n++) xe[n - 1] = e[9 - n];
        for (int i = 0; i < 9; i++) xc[i * 6 +: 6] = cd[i][5:0];
        chk("ind_en", ch_enable_o, xe);
        chk("ind_code", ch_code_o, xc);
        // Global mode over every unused-channel count.
        for (int n = 0; n < 16; n++) begin
            host_u.wr(8'h02, 8'h82 | 8'(n << 2) | 8'(n & 1));
            settle();
            u = (n >= 8) ? 1 : 9 - n;
            m9 = (9'h001 << u) - 9'h001;
            mc = '0;
            xc = '0;
            for (int c = 0; c < u; c++) begin
                mc[c * 6 +: 6] = 6'h3F;
                xc[c * 6 +: 6] = g[5:0];
            end
            chk("glb_en", ch_enable_o, m9);
            chk("glb_code", ch_code_o & mc, xc);
        end
        host_u.wr(8'h02, 8'h80);
        settle();
        chk("glb_off", ch_enable_o, 9'h000);
        // Regulator enable and light-load sources against both pins.
        for (int i = 0; i < 64; i++) begin
            host_u.wr(8'h11, 8'hF0 | 8'(i & 15));
            @(posedge clock_i);
            chip_en_i <= i[4];
            mode_pin_i <= i[5];
            settle();
            chk("run", regulator_run_o, i[3] ? (i[2] & i[4]) : i[4]);
            chk("skip", light_load_skip_o, i[1] ? i[0] : i[5]);
        end
        rdx(8'h11, 8'h0F);
        rdx(8'h02, 8'h80);
        // Live status, then the latched copy, then the clear command.
        for (int j = 0; j < 2; j++) begin
            s = j ? 4'hA : 4'h5;
            @(posedge clock_i);
            {vin_uv_i, vin_ov_i, reg_ocp_i, die_hot_i} <= s;
            settle();
            rdx(8'h13, {3'h0, s, 1'b0});
            @(posedge clock_i);
            {vin_uv_i, vin_ov_i, reg_ocp_i, die_hot_i} <= 4'h0;
            settle();
            rdx(8'h13, 8'h00);
            rdx(8'h0F, {4'h0, s[2:0], 1'b0});
            host_u.wr(8'h10, 8'h01);
            settle();
            rdx(8'h0F, 8'h00);
            rdx(8'h10, 8'h00);
        end
        // Open channels one and nine in individual mode.
        host_u.wr(8'h03, 8'hFF);
        host_u.wr(8'h02, 8'h01);
        settle();
        @(posedge clock_i);
        open_detect_i <= 9'h101;
        settle();
        chk("open_en", ch_enable_o, 9'h0FE);
        chk("fault_oe", fault_oe_o, 1'b1);
        chk("fault_lvl", fault_o, 1'b0);
        rdx(8'h0E, 8'hA0);
        rdx(8'h0F, 8'h20);
        // A clear while the open persists must not take.
        host_u.wr(8'h10, 8'h01);
        settle();
        rdx(8'h0E, 8'hA0);
        @(posedge clock_i);
        open_detect_i <= 9'h000;
        settle();
        chk("held_oe", fault_oe_o, 1'b1);
        chk("held_en", ch_enable_o, 9'h0FE);
        @(posedge clock_i);
        fault_reset_i <= 1'b1;
        @(posedge clock_i);
        fault_reset_i <= 1'b0;
        settle();
        chk("rel_oe", fault_oe_o, 1'b0);
        chk("rel_en", ch_enable_o, 9'h1FF);
        rdx(8'h0E, 8'h00);
        rdx(8'h0F, 8'h00);
        settle();
        // A second power-on reset restores defaults.
        @(posedge clock_i);
        arst_n_i <= 1'b0;
        @(posedge clock_i);
        arst_n_i <= 1'b1;
        rdx(8'h03, 8'h00);
        settle();
        chk("drain", exp_q.size(), 0);
        conclude();
    end
endmodule : tb_lsc_regs
`default_nettype wire

// *** core/lsc_defs.svh ***
`ifndef LSC_DEFS_SVH
`define LSC_DEFS_SVH

// Register offsets on the byte-wide register port.
`define LSC_ADDR_CFG 8'h02
`define LSC_ADDR_EN29 8'h03
`define LSC_ADDR_GCUR 8'h04
`define LSC_ADDR_CH1 8'h05
`define LSC_ADDR_CH9 8'h0D
`define LSC_ADDR_FST1 8'h0E
`define LSC_ADDR_FST2 8'h0F
`define LSC_ADDR_FCLR 8'h10
`define LSC_ADDR_BUCK 8'h11
`define LSC_ADDR_STAT 8'h13

// Field positions in the configuration register.
`define LSC_CFG_SCHEME 7
`define LSC_CFG_UNUSED_HI 5
`define LSC_CFG_UNUSED_LO 2
`define LSC_CFG_GEN 1
`define LSC_CFG_CH1EN 0

// Field positions in the fault, clear, regulator and status registers.
`define LSC_FST1_ANY 7
`define LSC_FST2_OV 3
`define LSC_FST2_OCP 2
`define LSC_FST2_OT 1
`define LSC_FCLR_BIT 0
`define LSC_BUCK_ENSRC 3
`define LSC_BUCK_SOFTEN 2
`define LSC_BUCK_MODESRC 1
`define LSC_BUCK_MODESW 0
`define LSC_STAT_UV 4
`define LSC_STAT_OV 3
`define LSC_STAT_OCP 2
`define LSC_STAT_OT 1

// Writable-bit masks, reset values and sizes.
`define LSC_CFG_MASK 8'hBF
`define LSC_CODE_MASK 8'h3F
`define LSC_BUCK_MASK 8'h0F
`define LSC_RESET_BYTE 8'h00
`define LSC_NUM_CH 9
`define LSC_CODE_W 6

`endif

// *** core/lsc_pkg.sv ***
package lsc_pkg;

    // Control scheme chosen by the top bit of the configuration register.
    typedef enum logic {
        LSC_INDIVIDUAL,
        LSC_GLOBAL
    } lsc_scheme_t;

    // One current code per channel.
    typedef logic [5:0] lsc_code_t;

endpackage : lsc_pkg

// *** core/lsc_regs.sv ***
// Operation
// [RQ1] Config bit 7 picks individual or global control.
// [RQ2] Unused count drops channels from nine downward.
// [RQ3] Config bit 1 enables used channels globally.
// [RQ4] Individual enables: ch1 bit0, ch2-9 second register.
// [RQ5] Global current follows shared six-bit code.
// [RQ6] Individual current from own code, bits 7:6 reserved.
// [RQ7] Fault register A bit 7 shows any open.
// [RQ8] Per-channel open flags across both fault registers.
// [RQ9] Register B latches overvoltage, overcurrent, overheat.
// [RQ10] Writing one to clear bit clears faults.
// [RQ11] Regulator enable source: pin or software.
// [RQ12] Software enable also needs chip enable high.
// [RQ13] Light-load mode source: pin or software.
// [RQ14] Software mode bit: forced PWM or skip.
// [RQ15] Status register shows live supply and thermal conditions.
// [RQ16] Reserved bits read zero, reset zero.
// [RQ17] Open channel off until gone and cleared.
// [RQ18] Fault-reset pin high also clears faults.
// [RQ19] Fault pin low while any open latched.
// [RQ20] Only power-on reset restores register defaults.
// [RQ21] Mode ignores the other mode's fields.
`timescale 1ns/1ps
`default_nettype none
`include "lsc_defs.svh"

module lsc_regs (
    // Clock and power-on reset.
    input wire logic clock_i,
    input wire logic arst_n_i,
    // Byte register port, driven by the serial slave front end.
    input wire logic [7:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [7:0] reg_rdata_o,
    output logic reg_rvalid_o,
    // Analog monitors, channel one at bit 0.
    input wire logic [8:0] open_detect_i,
    input wire logic vin_uv_i,
    input wire logic vin_ov_i,
    input wire logic reg_ocp_i,
    input wire logic die_hot_i,
    // Pins.
    input wire logic chip_en_i,
    input wire logic mode_pin_i,
    input wire logic fault_reset_i,
    output logic fault_o,
    output logic fault_oe_o,
    // Controls toward the sinks and the regulator.
    output logic [8:0] ch_enable_o,
    output logic [53:0] ch_code_o,
    output logic regulator_run_o,
    output logic light_load_skip_o
);

    // Channels in use for a given unused-channel count; counts of eight
    // and above all leave channel one alone.
    function automatic logic [8:0] used_mask(input logic [3:0] unused);
        logic [8:0] m;
        m = 9'h1FF;
        if (unused >= 4'h8) begin
            m = 9'h001;
        end else begin
            m = 9'h1FF >> unused;
        end
        return m;
    endfunction : used_mask

    // Register storage.
    logic [7:0] cfg_ff;
    logic [7:0] en29_ff;
    logic [7:0] gcur_ff;
    logic [7:0] chcur_ff [0:8];
    logic [7:0] buck_ff;
    logic [8:0] open_lat_ff;
    logic ov_lat_ff;
    logic ocp_lat_ff;
    logic ot_lat_ff;
    logic [7:0] rdata_ff;
    logic rvalid_ff;
    logic [8:0] ch_enable_ff;
    logic [53:0] ch_code_ff;
    logic regulator_run_ff;
    logic skip_ff;
    logic fault_oe_ff;

    // Decoded strobes and views.
    logic clear_cmd;
    lsc_pkg::lsc_scheme_t scheme;
    logic [8:0] wanted_en;
    logic [8:0] nxt_ch_enable;
    logic [53:0] nxt_ch_code;
    logic [7:0] fst1;
    logic [7:0] fst2;
    logic [7:0] stat;
    logic [7:0] nxt_rdata;

    // Writing one to the clear bit, or a high fault-reset pin, clears faults.
    assign clear_cmd = (reg_wr_i && reg_addr_i == `LSC_ADDR_FCLR &&
                        reg_wdata_i[`LSC_FCLR_BIT]) || fault_reset_i; // RQ10 RQ18

    assign scheme = lsc_pkg::lsc_scheme_t'(cfg_ff[`LSC_CFG_SCHEME]); // RQ1

    // Control registers; reserved bits are masked so they stay zero. Only
    // the power-on reset touches them, the chip enable pin never does.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cfg_ff <= `LSC_RESET_BYTE; // RQ20
            en29_ff <= `LSC_RESET_BYTE;
            gcur_ff <= `LSC_RESET_BYTE;
            buck_ff <= `LSC_RESET_BYTE;
        end else if (reg_wr_i) begin
            if (reg_addr_i == `LSC_ADDR_CFG) begin
                cfg_ff <= reg_wdata_i & `LSC_CFG_MASK; // RQ16
            end else if (reg_addr_i == `LSC_ADDR_EN29) begin
                en29_ff <= reg_wdata_i;
            end else if (reg_addr_i == `LSC_ADDR_GCUR) begin
                gcur_ff <= reg_wdata_i & `LSC_CODE_MASK;
            end else if (reg_addr_i == `LSC_ADDR_BUCK) begin
                buck_ff <= reg_wdata_i & `LSC_BUCK_MASK; // RQ16
            end
        end
    end

    // Per-channel current codes, one byte each at consecutive offsets.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            for (int i = 0; i < `LSC_NUM_CH; i++) begin
                chcur_ff[i] <= `LSC_RESET_BYTE;
            end
        end else if (reg_wr_i && reg_addr_i >= `LSC_ADDR_CH1 &&
                     reg_addr_i <= `LSC_ADDR_CH9) begin
            chcur_ff[4'(reg_addr_i - `LSC_ADDR_CH1)] <= reg_wdata_i & `LSC_CODE_MASK; // RQ6
        end
    end

    // Open flags latch only for channels that are requested (wanted_en); a new
    // detection wins over a clear in the same cycle, so a still-open
    // channel stays flagged and stays off after the clear.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            open_lat_ff <= 9'h000;
        end else begin
            open_lat_ff <= (clear_cmd ? 9'h000 : open_lat_ff) |
                           (open_detect_i & wanted_en); // RQ8 RQ17
        end
    end

    // Overvoltage, overcurrent and thermal faults latch; set beats clear.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ov_lat_ff <= 1'b0;
            ocp_lat_ff <= 1'b0;
            ot_lat_ff <= 1'b0;
        end else begin
            ov_lat_ff <= vin_ov_i || (ov_lat_ff && !clear_cmd); // RQ9
            ocp_lat_ff <= reg_ocp_i || (ocp_lat_ff && !clear_cmd); // RQ9
            ot_lat_ff <= die_hot_i || (ot_lat_ff && !clear_cmd); // RQ9
        end
    end

    // Requested channel enables and codes for the active scheme; fields
    // of the other scheme are not looked at.
    always_comb begin
        wanted_en = 9'h000;
        nxt_ch_code = '0;
        case (scheme)
            lsc_pkg::LSC_GLOBAL: begin
                if (cfg_ff[`LSC_CFG_GEN]) begin // RQ3
                    wanted_en = used_mask(cfg_ff[`LSC_CFG_UNUSED_HI:`LSC_CFG_UNUSED_LO]); // RQ2
                end
                for (int i = 0; i < `LSC_NUM_CH; i++) begin
                    nxt_ch_code[i*`LSC_CODE_W +: `LSC_CODE_W] = gcur_ff[5:0]; // RQ5 RQ21
                end
            end
            default: begin
                wanted_en[0] = cfg_ff[`LSC_CFG_CH1EN]; // RQ4
                for (int i = 1; i < `LSC_NUM_CH; i++) begin
                    wanted_en[i] = en29_ff[8 - i]; // RQ4 RQ21
                end
                for (int i = 0; i < `LSC_NUM_CH; i++) begin
                    nxt_ch_code[i*`LSC_CODE_W +: `LSC_CODE_W] = chcur_ff[i][5:0]; // RQ6
                end
            end
        endcase
    end

    // A latched open channel is switched off; the others run on.
    assign nxt_ch_enable = wanted_en & ~open_lat_ff; // RQ17

    // Sink controls are registered so the analog side sees clean levels.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            ch_enable_ff <= 9'h000;
            ch_code_ff <= '0;
        end else begin
            ch_enable_ff <= nxt_ch_enable;
            ch_code_ff <= nxt_ch_code;
        end
    end

    // Regulator enable and light-load mode sources. Software enable still
    // needs the chip enable pin, so a low pin always stops the regulator.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            regulator_run_ff <= 1'b0;
            skip_ff <= 1'b0;
        end else begin
            if (buck_ff[`LSC_BUCK_ENSRC]) begin // RQ11
                regulator_run_ff <= buck_ff[`LSC_BUCK_SOFTEN] && chip_en_i; // RQ12
            end else begin
                regulator_run_ff <= chip_en_i;
            end
            if (buck_ff[`LSC_BUCK_MODESRC]) begin // RQ13
                skip_ff <= buck_ff[`LSC_BUCK_MODESW]; // RQ14
            end else begin
                skip_ff <= mode_pin_i;
            end
        end
    end

    // Fault pin pulls low while any open flag is latched.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            fault_oe_ff <= 1'b0;
        end else begin
            fault_oe_ff <= |open_lat_ff; // RQ19
        end
    end

    // Read views of the fault and status registers.
    always_comb begin
        fst1 = 8'h00;
        fst1[`LSC_FST1_ANY] = |open_lat_ff; // RQ7
        for (int i = 0; i < 6; i++) begin
            fst1[5 - i] = open_lat_ff[i]; // RQ8
        end
        fst2 = 8'h00;
        for (int i = 0; i < 3; i++) begin
            fst2[7 - i] = open_lat_ff[6 + i]; // RQ8
        end
        fst2[`LSC_FST2_OV] = ov_lat_ff;
        fst2[`LSC_FST2_OCP] = ocp_lat_ff;
        fst2[`LSC_FST2_OT] = ot_lat_ff;
        stat = 8'h00; // RQ16
        stat[`LSC_STAT_UV] = vin_uv_i; // RQ15
        stat[`LSC_STAT_OV] = vin_ov_i;
        stat[`LSC_STAT_OCP] = reg_ocp_i;
        stat[`LSC_STAT_OT] = die_hot_i;
    end

    // Read decode; the clear register and unmapped offsets read zero.
    always_comb begin
        nxt_rdata = 8'h00;
        if (reg_addr_i == `LSC_ADDR_CFG) begin
            nxt_rdata = cfg_ff;
        end else if (reg_addr_i == `LSC_ADDR_EN29) begin
            nxt_rdata = en29_ff;
        end else if (reg_addr_i == `LSC_ADDR_GCUR) begin
            nxt_rdata = gcur_ff;
        end else if (reg_addr_i >= `LSC_ADDR_CH1 && reg_addr_i <= `LSC_ADDR_CH9) begin
            nxt_rdata = chcur_ff[4'(reg_addr_i - `LSC_ADDR_CH1)];
        end else if (reg_addr_i == `LSC_ADDR_FST1) begin
            nxt_rdata = fst1;
        end else if (reg_addr_i == `LSC_ADDR_FST2) begin
            nxt_rdata = fst2;
        end else if (reg_addr_i == `LSC_ADDR_BUCK) begin
            nxt_rdata = buck_ff;
        end else if (reg_addr_i == `LSC_ADDR_STAT) begin
            nxt_rdata = stat;
        end
    end

    // Read data is captured one cycle after the strobe and held.
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdata_ff <= 8'h00;
            rvalid_ff <= 1'b0;
        end else begin
            rvalid_ff <= reg_rd_i;
            if (reg_rd_i) begin
                rdata_ff <= nxt_rdata;
            end
        end
    end

    assign reg_rdata_o = rdata_ff;
    assign reg_rvalid_o = rvalid_ff;
    assign ch_enable_o = ch_enable_ff;
    assign ch_code_o = ch_code_ff;
    assign regulator_run_o = regulator_run_ff;
    assign light_load_skip_o = skip_ff;
    assign fault_o = 1'b0; // Open drain: only ever pulls low.
    assign fault_oe_o = fault_oe_ff;

    // Checks next to the logic they guard.
    a_global_count: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RQ2
        (cfg_ff[7] && cfg_ff[1] && cfg_ff[5:2] == 4'h1 && open_lat_ff == 9'h000)
        |=> ch_enable_o == 9'h0FF)
        else $error("global count one must drop only channel nine");

    a_global_off: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RQ3
        (cfg_ff[7] && !cfg_ff[1]) |=> ch_enable_o == 9'h000)
        else $error("global disable left a channel on");

    a_indiv_ch2: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RQ4
        (!cfg_ff[7] && !open_lat_ff[1]) |=> ch_enable_o[1] == $past(en29_ff[7]))
        else $error("channel two enable not taken from bit seven");

    a_global_code: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RQ5
        cfg_ff[7] |=> ch_code_o[53:48] == $past(gcur_ff[5:0]))
        else $error("channel nine code not the shared code");

    a_open_off: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RQ17
        open_lat_ff[0] |=> !ch_enable_o[0])
        else $error("open channel still enabled");

    a_open_any: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RQ7
        (reg_rd_i && reg_addr_i == 8'h0E) |=> reg_rdata_o[7] == $past(|open_lat_ff))
        else $error("any-open flag read wrong");

    a_clear_open: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RQ10
        (reg_wr_i && reg_addr_i == 8'h10 && reg_wdata_i[0] && open_detect_i == 9'h000)
        |=> open_lat_ff == 9'h000 && ov_lat_ff == $past(vin_ov_i))
        else $error("clear command left an open flag");

    a_reset_pin: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RQ18
        (fault_reset_i && open_detect_i == 9'h000) ##1 (!fault_reset_i) [*2]
        |-> !fault_oe_o)
        else $error("fault pin held after reset pin clear");

    a_ov_sticky: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RQ9
        (vin_ov_i && !clear_cmd) ##1 !clear_cmd |=> fst2[3])
        else $error("overvoltage flag did not hold");

    a_buck_soft: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RQ12
        (buck_ff[3] && !chip_en_i) |=> !regulator_run_o)
        else $error("regulator runs without chip enable");

    a_mode_soft: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RQ14
        buck_ff[1] |=> light_load_skip_o == $past(buck_ff[0]))
        else $error("light-load mode not from software bit");

    a_fault_pin: assert property (@(posedge clock_i) disable iff (!arst_n_i) // RQ19
        $rose(|open_lat_ff) |=> fault_oe_o)
        else $error("fault pin not pulled on open");

endmodule : lsc_regs

`default_nettype wire
